/* File: logic/can_lp_cfg.svh */
// Offsets, field positions, reset values and timing counts of the CAN low-power control block.
// Assumes inclusion by bare name from the package and the self-checking bench.
`ifndef CAN_LP_CFG_SVH
`define CAN_LP_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define LP_CTRL_OFFSET 12'h000
`define LP_STATUS_OFFSET 12'h004
`define LP_PENDING_OFFSET 12'h008
`define LP_BUSOFF_OFFSET 12'h00C
`define LP_RXBUF_OFFSET 12'h010

// ****************************************************************
// Control fields
// ****************************************************************
`define CTRL_SLEEP_REQUEST_BIT 0
`define CTRL_WAKE_UP_ENABLE_BIT 1
`define CTRL_STOP_IN_WAIT_BIT 2
`define CTRL_RESET_VALUE 32'h00000000

// ****************************************************************
// Status fields
// ****************************************************************
`define STAT_SLEEP_ACK_BIT 0
`define STAT_SYNCH_BIT 1
`define STAT_BUSOFF_BIT 2
`define STAT_POWER_DOWN_BIT 3
`define STAT_RECOVERY_BIT 4
`define STAT_FG_FULL_BIT 5
`define STAT_BG_FULL_BIT 6
`define STAT_TX_BUSY_BIT 7

// ****************************************************************
// Pending action fields
// ****************************************************************
`define PEND_COPY_BIT 0
`define PEND_ABORT_BIT 1
`define PEND_TX_BIT 2

// ****************************************************************
// Timing counts
// ****************************************************************
`define RECESSIVE_BITS_SYNCH 11
`define BUSOFF_SEQUENCES 128
`define BIT_TIME_NS 2000
`define BIT_CYCLES ((`BIT_TIME_NS + 9) / 10)
`define RECOVERY_TIME_NS 1000
`define RECOVERY_CYCLES ((`RECOVERY_TIME_NS + 9) / 10)

`endif

/* File: logic/can_lp_pkg.sv */
// Types shared by the CAN low-power control block.
// Assumes the configuration header is on the include path.
`include "can_lp_cfg.svh"

package can_lp_pkg;

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'h0,
		MODE_SLEEP_WAIT = 3'h1,
		MODE_SLEEP = 3'h3,
		MODE_SYNCH = 3'h2,
		MODE_RECOVERY = 3'h6,
		MODE_POWER_DOWN = 3'h4
	} lp_mode_type;

	typedef struct packed {
		logic sleep_request;
		logic wake_up_enable;
		logic stop_in_wait;
	} ctrl_type;

	typedef struct packed {
		logic bit_tick;
		logic recessive;
		logic dominant_edge;
	} bus_sense_type;

	typedef struct packed {
		logic [7:0] count;
		logic done;
	} run_count_type;

endpackage : can_lp_pkg

/* File: logic/can_bit_divider.sv */
// Bit-rate enable divider for the CAN low-power control block.
// Assumes one clock; emits a one-cycle tick every DIVIDE cycles while run is high.
`timescale 1ns/100ps

module can_bit_divider import can_lp_pkg::*; #(
	parameter int DIVIDE = `BIT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	output logic tick
);

	typedef struct packed {
		logic [15:0] count;
		logic tick;
	} div_state_type;

	div_state_type state_reg;
	div_state_type state_next;

	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (!run) begin
			state_next.count = 16'h0000;
		end else if (state_reg.count == 16'(DIVIDE - 1)) begin
			state_next.count = 16'h0000;
			state_next.tick = 1'b1;
		end else begin
			state_next.count = state_reg.count + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tick = state_reg.tick;

endmodule : can_bit_divider

/* File: logic/can_recessive_counter.sv */
// Counts consecutive recessive bit times; a pulse marks each run of LENGTH bits.
// Assumes the sampled bus level and a bit tick from the divider.
`timescale 1ns/100ps

module can_recessive_counter import can_lp_pkg::*; #(
	parameter int LENGTH = `RECESSIVE_BITS_SYNCH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire bus_sense_type sense,
	output run_count_type run
);

	run_count_type state_reg;
	run_count_type state_next;

	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;
		if (clear || (sense.bit_tick && !sense.recessive)) begin
			state_next.count = 8'h00;
		end else if (sense.bit_tick) begin
			if (state_reg.count == 8'(LENGTH - 1)) begin
				state_next.count = 8'h00;
				state_next.done = 1'b1;
			end else begin
				state_next.count = state_reg.count + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign run = state_reg;

endmodule : can_recessive_counter

/* File: logic/can_sleep_power_down_control.sv */
// Sleep and power-down control of a CAN controller, with an APB register slave.
// Assumes synchronous inputs on pclk; the protocol engine sits outside and obeys the
// abort, receive-level and receive-enable outputs of this block.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps

module can_sleep_power_down_control import can_lp_pkg::*; #(
	parameter int BIT_DIVIDE = `BIT_CYCLES,
	parameter int RECOVERY = `RECOVERY_CYCLES,
	parameter int BUF_WIDTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_stop,
	input wire logic cpu_wait,
	input wire logic can_receive_pin,
	output logic can_transmit_pin,
	input wire logic engine_tx_bit,
	input wire logic engine_busy,
	input wire logic engine_rx_valid,
	input wire logic [BUF_WIDTH-1:0] engine_rx_data,
	input wire logic engine_bus_off,
	input wire logic engine_tx_done,
	output logic engine_abort,
	output logic engine_rx_level,
	output logic engine_rx_enable,
	output logic engine_tx_start,
	output logic engine_tx_cancel,
	output logic engine_busoff_step
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		lp_mode_type mode;
		ctrl_type ctrl;
		logic slept_before;
		logic [15:0] recovery_count;
		logic [7:0] busoff_runs;
		logic [2:0] pending;
		logic fg_full;
		logic bg_full;
		logic [BUF_WIDTH-1:0] fg_data;
		logic [BUF_WIDTH-1:0] bg_data;
		logic rx_prev;
		logic tx_pin;
		logic abort;
		logic rx_level;
		logic rx_enable;
		logic tx_start;
		logic tx_cancel;
		logic busoff_step;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
	} lp_state_type;

	lp_state_type state_reg;
	lp_state_type state_next;

	bus_sense_type sense;
	run_count_type run;
	logic bit_tick;
	logic power_down_req;
	logic counting;
	logic run_clear;

	function automatic logic is_sleep_mode(input lp_mode_type m);
		return (m == MODE_SLEEP);
	endfunction : is_sleep_mode

	function automatic logic restarts_run(input lp_mode_type m);
		return (m == MODE_SLEEP) || (m == MODE_RECOVERY) || (m == MODE_POWER_DOWN);
	endfunction : restarts_run

	// ****************************************************************
	// Power-down request and bit timing
	// ****************************************************************
	assign power_down_req = cpu_stop || (cpu_wait && state_reg.ctrl.stop_in_wait);
	assign counting = (state_reg.mode != MODE_POWER_DOWN);
	// Synchronising always starts from an empty run of recessive bits
	assign run_clear = restarts_run(state_reg.mode);

	can_bit_divider #(
		.DIVIDE(BIT_DIVIDE)
	) u_divider (
		.pclk(pclk),
		.presetn(presetn),
		.run(counting),
		.tick(bit_tick)
	);

	// ****************************************************************
	// Bus sensing
	// ****************************************************************
	always_comb begin
		sense.bit_tick = bit_tick;
		sense.recessive = state_reg.rx_level;
		sense.dominant_edge = state_reg.rx_prev && !can_receive_pin;
	end

	can_recessive_counter #(
		.LENGTH(`RECESSIVE_BITS_SYNCH)
	) u_recessive (
		.pclk(pclk),
		.presetn(presetn),
		.clear(run_clear),
		.sense(sense),
		.run(run)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic acc;
		logic wr;
		logic rd;
		logic asleep;
		logic [2:0] pend_set;
		state_next = state_reg;
		acc = psel && penable && !state_reg.ready;
		wr = acc && pwrite;
		rd = acc && !pwrite;
		asleep = is_sleep_mode(state_reg.mode);
		pend_set = (wr && paddr == `LP_PENDING_OFFSET && state_reg.mode != MODE_POWER_DOWN) ?
			pwdata[2:0] : 3'h0;
		state_next.ready = 1'b0;
		state_next.slverr = 1'b0;
		state_next.tx_start = 1'b0;
		state_next.tx_cancel = 1'b0;
		state_next.busoff_step = 1'b0;
		state_next.abort = 1'b0;
		state_next.rx_prev = can_receive_pin;

		// Bus receive path, masked in sleep without wake-up enable
		if (asleep && !state_reg.ctrl.wake_up_enable) begin
			state_next.rx_level = 1'b1;
		end else begin
			state_next.rx_level = can_receive_pin;
		end

		// Register access; no answer while powered down
		if (acc && state_reg.mode != MODE_POWER_DOWN) begin
			state_next.ready = 1'b1;
			case (paddr)
				`LP_CTRL_OFFSET: begin
					if (wr) begin
						state_next.ctrl.wake_up_enable = pwdata[`CTRL_WAKE_UP_ENABLE_BIT];
						state_next.ctrl.stop_in_wait = pwdata[`CTRL_STOP_IN_WAIT_BIT];
						if (pwdata[`CTRL_SLEEP_REQUEST_BIT]) begin
							state_next.ctrl.sleep_request = 1'b1;
						end else if (asleep) begin
							state_next.ctrl.sleep_request = 1'b0;
						end
					end
					state_next.rdata = {29'h0, state_reg.ctrl.stop_in_wait,
						state_reg.ctrl.wake_up_enable, state_reg.ctrl.sleep_request};
				end
				`LP_STATUS_OFFSET: begin
					state_next.rdata = {24'h0, engine_busy, state_reg.bg_full,
						state_reg.fg_full, state_reg.mode == MODE_RECOVERY, 1'b0,
						engine_bus_off, state_reg.mode == MODE_NORMAL, asleep};
				end
				`LP_PENDING_OFFSET: begin
					if (wr) begin
						state_next.pending = state_reg.pending | pwdata[2:0];
					end
					state_next.rdata = {29'h0, state_reg.pending};
				end
				`LP_BUSOFF_OFFSET: begin
					state_next.rdata = {24'h0, state_reg.busoff_runs};
				end
				`LP_RXBUF_OFFSET: begin
					state_next.rdata = 32'(state_reg.fg_data);
					if (rd && state_reg.fg_full) begin
						state_next.fg_full = 1'b0;
						state_next.pending[`PEND_COPY_BIT] = state_reg.bg_full;
					end
				end
				default: begin
					state_next.rdata = 32'h00000000;
					state_next.slverr = 1'b1;
				end
			endcase
		end

		// Receive buffers hold through sleep; reception only when synchronised
		if (engine_rx_valid && state_reg.rx_enable) begin
			if (!state_next.fg_full) begin
				state_next.fg_data = engine_rx_data;
				state_next.fg_full = 1'b1;
			end else begin
				state_next.bg_data = engine_rx_data;
				state_next.bg_full = 1'b1;
			end
		end
		if (engine_tx_done) begin
			state_next.pending[`PEND_TX_BIT] = 1'b0;
		end

		// Bus-off runs are counted in normal mode and kept over sleep
		if (!engine_bus_off) begin
			state_next.busoff_runs = 8'h00;
		end else if (run.done && state_reg.mode == MODE_NORMAL) begin
			state_next.busoff_step = 1'b1;
			if (state_reg.busoff_runs == 8'(`BUSOFF_SEQUENCES - 1)) begin
				state_next.busoff_runs = 8'h00;
			end else begin
				state_next.busoff_runs = state_reg.busoff_runs + 8'h01;
			end
		end

		// Mode sequencing
		case (state_reg.mode)
			MODE_NORMAL: begin
				if (state_reg.ctrl.sleep_request) begin
					state_next.mode = MODE_SLEEP_WAIT;
				end
			end
			MODE_SLEEP_WAIT: begin
				if (!engine_busy) begin
					state_next.mode = MODE_SLEEP;
					state_next.rx_enable = 1'b0;
				end
			end
			MODE_SLEEP: begin
				if (!state_reg.ctrl.sleep_request ||
					(state_reg.ctrl.wake_up_enable && sense.dominant_edge)) begin
					state_next.mode = MODE_SYNCH;
					state_next.ctrl.sleep_request = 1'b0;
					state_next.rx_enable = 1'b0;
				end
			end
			MODE_SYNCH: begin
				if (run.done && !power_down_req) begin
					state_next.mode = MODE_NORMAL;
					state_next.rx_enable = 1'b1;
					if (state_reg.pending[`PEND_COPY_BIT] && !state_reg.fg_full) begin
						state_next.fg_data = state_reg.bg_data;
						state_next.fg_full = 1'b1;
						state_next.bg_full = 1'b0;
						state_next.pending[`PEND_COPY_BIT] = 1'b0;
					end
					state_next.tx_cancel = state_reg.pending[`PEND_ABORT_BIT];
					state_next.pending[`PEND_ABORT_BIT] = 1'b0;
					state_next.tx_start = state_reg.pending[`PEND_TX_BIT] &&
						!state_reg.pending[`PEND_ABORT_BIT];
				end
			end
			MODE_RECOVERY: begin
				if (state_reg.recovery_count == 16'h0000) begin
					state_next.mode = MODE_SYNCH;
				end else begin
					state_next.recovery_count = state_reg.recovery_count - 16'h0001;
				end
			end
			MODE_POWER_DOWN: begin
				if (!power_down_req) begin
					if (state_reg.slept_before) begin
						state_next.mode = MODE_SLEEP;
					end else begin
						state_next.mode = MODE_RECOVERY;
						state_next.recovery_count = 16'(RECOVERY - 1);
					end
				end
			end
			default: begin
				state_next.mode = MODE_NORMAL;
			end
		endcase

		// Power-down entry overrides the mode, receive enable and access answer; software should have slept first
		if (power_down_req && state_reg.mode != MODE_POWER_DOWN) begin
			state_next.mode = MODE_POWER_DOWN;
			state_next.slept_before = asleep;
			state_next.abort = !asleep;
			state_next.rx_enable = 1'b0;
			state_next.ready = 1'b0;
		end

		// A software set of a pending action wins over its clear in the same cycle
		state_next.pending = state_next.pending | pend_set;
		if (state_next.mode == MODE_POWER_DOWN || asleep) begin
			state_next.tx_pin = 1'b1;
		end else begin
			state_next.tx_pin = engine_tx_bit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			state_reg.mode <= MODE_SYNCH;
			state_reg.tx_pin <= 1'b1;
			state_reg.rx_level <= 1'b1;
			state_reg.rx_prev <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata = state_reg.rdata;
	assign pready = state_reg.ready;
	assign pslverr = state_reg.slverr;
	assign can_transmit_pin = state_reg.tx_pin;
	assign engine_abort = state_reg.abort;
	assign engine_rx_level = state_reg.rx_level;
	assign engine_rx_enable = state_reg.rx_enable;
	assign engine_tx_start = state_reg.tx_start;
	assign engine_tx_cancel = state_reg.tx_cancel;
	assign engine_busoff_step = state_reg.busoff_step;

endmodule : can_sleep_power_down_control

/* File: tb/can_lp_checker.sv */
// Port assertions for the CAN low-power control block.
// Assumes a bind to the top module; one clock domain.
`timescale 1ns/100ps
module can_lp_checker #(
	parameter int BIT_DIVIDE = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pready,
	input wire logic cpu_stop,
	input wire logic cpu_wait,
	input wire logic can_receive_pin,
	input wire logic can_transmit_pin,
	input wire logic engine_bus_off,
	input wire logic engine_abort,
	input wire logic engine_rx_level,
	input wire logic engine_rx_enable,
	input wire logic engine_tx_start,
	input wire logic engine_tx_cancel,
	input wire logic engine_busoff_step
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] run_reg;
	// Consecutive recessive cycles on the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) run_reg <= 16'h0000;
		else if (!can_receive_pin) run_reg <= 16'h0000;
		else if (run_reg != 16'hFFFF) run_reg <= run_reg + 16'h0001;
	end
	a_stop_tx_recessive: assert property (cpu_stop |=> can_transmit_pin)
		else $error("tx not recessive in stop");
	a_stop_no_ready: assert property (cpu_stop && $past(cpu_stop) && $past(cpu_stop, 2)
		|-> !pready)
		else $error("access answered in stop");
	a_abort_on_entry: assert property (engine_abort |-> $past(cpu_stop) || $past(cpu_wait))
		else $error("abort without power-down");
	a_stop_rx_off: assert property (cpu_stop |=> !engine_rx_enable)
		else $error("rx enabled in stop");
	a_synch_after_run: assert property ($rose(engine_rx_enable) |-> run_reg >= 9 * BIT_DIVIDE)
		else $error("synch without recessive run");
	a_rx_level_follows: assert property (!engine_rx_level |-> !$past(can_receive_pin))
		else $error("rx level dominant without bus");
	a_busoff_step: assert property (engine_busoff_step |-> $past(engine_bus_off))
		else $error("bus-off step while not bus-off");
	a_actions_at_wake: assert property (engine_tx_start || engine_tx_cancel
		|-> $rose(engine_rx_enable))
		else $error("pending action off wake edge");
	a_recovery_wait: assert property ($fell(cpu_stop) |-> !engine_rx_enable [*8])
		else $error("normal too soon after stop");
endmodule : can_lp_checker

bind can_sleep_power_down_control can_lp_checker #(.BIT_DIVIDE(BIT_DIVIDE)) chk (
	.pclk(pclk), .presetn(presetn), .pready(pready), .cpu_stop(cpu_stop),
	.cpu_wait(cpu_wait), .can_receive_pin(can_receive_pin),
	.can_transmit_pin(can_transmit_pin), .engine_bus_off(engine_bus_off),
	.engine_abort(engine_abort), .engine_rx_level(engine_rx_level),
	.engine_rx_enable(engine_rx_enable), .engine_tx_start(engine_tx_start),
	.engine_tx_cancel(engine_tx_cancel), .engine_busoff_step(engine_busoff_step)
);

/* File: tb/can_bus_node.sv */
// Behavioural model of the other nodes on the CAN bus.
// Assumes a wired-AND bus pulled recessive; go starts one frame.
`timescale 1ns/100ps
module can_bus_node #(
	parameter int BIT_DIVIDE = 2,
	parameter int FRAME_BITS = 30
) (
	input wire logic pclk,
	input wire logic go,
	input wire logic tx_level,
	output logic bus_level
);
	int left = 0;
	logic drive = 1'b1;
	// Dominant from either side wins
	assign bus_level = tx_level & drive;
	always @(posedge pclk) begin
		if (go) begin
			left <= FRAME_BITS * BIT_DIVIDE;
			drive <= 1'b0;
		end else if (left > 0) begin
			left <= left - 1;
			drive <= (left == 1) | ((left - 1) / BIT_DIVIDE % 2 == 1);
		end
	end
endmodule : can_bus_node

/* File: tb/can_sleep_power_down_control_test.sv */
// Self-checking bench for the CAN low-power control block.
// Assumes the bus node model and the bound checker.
`timescale 1ns/100ps
`include "can_lp_cfg.svh"
module can_sleep_power_down_control_test;
	localparam int BD = 2;
	localparam int RC = 4;
	localparam logic [11:0] CT = `LP_CTRL_OFFSET;
	localparam logic [11:0] ST = `LP_STATUS_OFFSET;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rx_data = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, rx_pin, tx_pin, abort, rx_level, rx_en, tx_start;
	logic cpu_stop = 1'b0;
	logic cpu_wait = 1'b0;
	logic tx_bit = 1'b1;
	logic busy = 1'b0;
	logic rx_valid = 1'b0;
	logic go = 1'b0;
	logic bus_off = 1'b0;
	logic tx_cancel, step;
	int fail_count = 0;
	int total_checks = 0;
	int aborts = 0;
	int starts = 0;
	int readies = 0;
	int cancels = 0;
	int steps = 0;
	can_sleep_power_down_control #(.BIT_DIVIDE(BD), .RECOVERY(RC)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_stop(cpu_stop), .cpu_wait(cpu_wait), .can_receive_pin(rx_pin),
		.can_transmit_pin(tx_pin), .engine_tx_bit(tx_bit), .engine_busy(busy),
		.engine_rx_valid(rx_valid), .engine_rx_data(rx_data), .engine_bus_off(bus_off),
		.engine_tx_done(1'b0), .engine_abort(abort), .engine_rx_level(rx_level),
		.engine_rx_enable(rx_en), .engine_tx_start(tx_start), .engine_tx_cancel(tx_cancel),
		.engine_busoff_step(step)
	);
	can_bus_node #(.BIT_DIVIDE(BD)) node (.pclk(pclk), .go(go), .tx_level(tx_pin),
		.bus_level(rx_pin));
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		if (abort === 1'b1) aborts++;
		if (tx_start === 1'b1) starts++;
		if (pready === 1'b1) readies++;
		if (tx_cancel === 1'b1) cancels++;
		if (step === 1'b1) steps++;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic chk1(input string s, input logic e, input logic g);
		chk(s, {31'h0, e}, {31'h0, g});
	endtask : chk1
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_en(output int n);
		n = 0;
		while (rx_en !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		chk1("rx_enable", 1'b1, rx_en);
	endtask : wait_en
	task automatic frame(input logic [31:0] d);
		@(posedge pclk);
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		rx_valid <= 1'b1;
		rx_data <= d;
		@(posedge pclk);
		rx_valid <= 1'b0;
	endtask : frame
	task automatic t_reset();
		int n;
		wait_en(n);
		apb(1'b0, CT, 32'h0);
		chk("ctrl", `CTRL_RESET_VALUE, rd);
		apb(1'b0, 12'hFFC, 32'h0);
		chk1("slverr", 1'b1, err);
		chk("unmapped", 32'h0, rd);
		$display("reset test done");
	endtask : t_reset
	task automatic t_sleep();
		int n;
		int s0;
		frame(32'hA5A50001);
		busy <= 1'b1;
		apb(1'b1, CT, 32'h1);
		apb(1'b1, CT, 32'h0);
		apb(1'b0, CT, 32'h0);
		chk1("refused clear", 1'b1, rd[`CTRL_SLEEP_REQUEST_BIT]);
		busy <= 1'b0;
		repeat (90) @(posedge pclk);
		apb(1'b1, `LP_PENDING_OFFSET, 32'h1 << `PEND_TX_BIT);
		frame(32'h5A5A0002);
		repeat (20) @(posedge pclk);
		chk1("masked rx", 1'b1, rx_level);
		apb(1'b0, ST, 32'h0);
		chk1("asleep", 1'b1, rd[`STAT_SLEEP_ACK_BIT]);
		s0 = starts;
		apb(1'b1, CT, 32'h0);
		wait_en(n);
		repeat (2) @(posedge pclk);
		chk("tx starts", 32'(s0 + 1), 32'(starts));
		apb(1'b0, `LP_RXBUF_OFFSET, 32'h0);
		chk("kept frame", 32'hA5A50001, rd);
		$display("sleep test done");
	endtask : t_sleep
	task automatic t_down();
		int n;
		int a0;
		int r0;
		busy <= 1'b1;
		tx_bit <= 1'b0;
		repeat (3) @(posedge pclk);
		chk1("tx driven", 1'b0, tx_pin);
		a0 = aborts;
		r0 = readies;
		cpu_stop <= 1'b1;
		repeat (2) @(posedge pclk);
		chk1("tx stop", 1'b1, tx_pin);
		fork
			apb(1'b0, ST, 32'h0);
			begin
				repeat (20) @(posedge pclk);
				chk("no access", 32'(r0), 32'(readies));
				chk("abort", 32'(a0 + 1), 32'(aborts));
				cpu_stop <= 1'b0;
				busy <= 1'b0;
				tx_bit <= 1'b1;
				wait_en(n);
				chk1("recovery", 1'b1, n >= RC + 10 * BD);
			end
		join
		$display("power-down test done");
	endtask : t_down
	task automatic t_wait();
		int n;
		int a0;
		busy <= 1'b1;
		tx_bit <= 1'b0;
		cpu_wait <= 1'b1;
		apb(1'b0, ST, 32'h0);
		chk1("wait ignored", 1'b1, rd[`STAT_SYNCH_BIT]);
		a0 = aborts;
		apb(1'b1, CT, 32'h4);
		repeat (3) @(posedge pclk);
		chk1("wait down", 1'b1, tx_pin);
		chk("wait abort", 32'(a0 + 1), 32'(aborts));
		cpu_wait <= 1'b0;
		busy <= 1'b0;
		tx_bit <= 1'b1;
		wait_en(n);
		apb(1'b1, CT, 32'h5);
		repeat (4) @(posedge pclk);
		a0 = aborts;
		cpu_stop <= 1'b1;
		repeat (10) @(posedge pclk);
		cpu_stop <= 1'b0;
		apb(1'b0, ST, 32'h0);
		chk1("back asleep", 1'b1, rd[`STAT_SLEEP_ACK_BIT]);
		chk("no abort", 32'(a0), 32'(aborts));
		apb(1'b1, CT, 32'h4);
		wait_en(n);
		$display("wait test done");
	endtask : t_wait
	task automatic t_wake();
		int n;
		apb(1'b1, CT, 32'h3);
		repeat (4) @(posedge pclk);
		frame(32'hC3C30003);
		wait_en(n);
		apb(1'b0, ST, 32'h0);
		chk1("woken", 1'b0, rd[`STAT_SLEEP_ACK_BIT]);
		chk1("lost frame", 1'b0, rd[`STAT_FG_FULL_BIT]);
		$display("wake test done");
	endtask : t_wake
	task automatic t_pending();
		int n;
		int s0;
		int c1;
		logic [31:0] c0;
		s0 = steps;
		bus_off <= 1'b1;
		repeat (100) @(posedge pclk);
		apb(1'b0, `LP_BUSOFF_OFFSET, 32'h0);
		c0 = rd;
		chk1("bus-off runs", 1'b1, c0 >= 32'h3 && steps > s0);
		frame(32'h11110004);
		frame(32'h22220005);
		apb(1'b0, `LP_RXBUF_OFFSET, 32'h0);
		chk("first frame", 32'h11110004, rd);
		apb(1'b1, CT, 32'h1);
		apb(1'b1, `LP_PENDING_OFFSET, 32'h1 << `PEND_ABORT_BIT);
		c1 = cancels;
		apb(1'b1, CT, 32'h0);
		wait_en(n);
		repeat (30) @(posedge pclk);
		chk("cancels", 32'(c1 + 1), 32'(cancels));
		apb(1'b0, `LP_RXBUF_OFFSET, 32'h0);
		chk("copied frame", 32'h22220005, rd);
		apb(1'b0, `LP_BUSOFF_OFFSET, 32'h0);
		chk1("runs kept", 1'b1, rd > c0);
		bus_off <= 1'b0;
		$display("pending test done");
	endtask : t_pending
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_sleep();
		t_down();
		t_wait();
		t_wake();
		t_pending();
		wrap_up();
	end
	initial begin
		#100000;
		fail_count++;
		wrap_up();
	end
endmodule : can_sleep_power_down_control_test
